// File: bit_period_divider.sv
// Divider that makes one tick per conversion bit period.
`timescale 1ns/10ps
`default_nettype none
module bit_period_divider (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic osc_tick_in,
  bit_period_if.div bp
);
  typedef struct packed {
    logic [4:0] count;
  } div_state_s;

  div_state_s st;
  div_state_s next_st;
  logic [4:0] divisor;
  logic step;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    case (bp.sel)
      sar_adc_pkg::sel_div16: divisor = sar_adc_pkg::div16;
      sar_adc_pkg::sel_div8: divisor = sar_adc_pkg::div8;
      default: divisor = sar_adc_pkg::div4;
    endcase
    step = (bp.sel == sar_adc_pkg::sel_osc) ? osc_tick_in : 1'b1;
    bp.tick = step && (st.count == divisor - 5'h01) && !bp.restart;
    if (bp.restart) begin
      next_st.count = 5'h00;
    end else if (bp.tick) begin
      next_st.count = 5'h00;
    end else if (step) begin
      next_st.count = st.count + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : bit_period_divider
`default_nettype wire

// File: bit_period_if.sv
// Interface between the sequencer and its bit period divider.
`timescale 1ns/10ps
`default_nettype none
interface bit_period_if;
  logic restart;
  logic [1:0] sel;
  logic tick;
  modport seq (output restart, output sel, input tick);
  modport div (input restart, input sel, output tick);
endinterface : bit_period_if
`default_nettype wire

// File: sar_adc_analog_model.sv
// Behavioural model of the analog inputs, hold capacitor and comparator.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_analog_model (
  input wire logic sys_clk_in,
  input wire logic [3:0] sample_channel_in,
  input wire logic sample_hold_in,
  input wire logic [7:0] trial_code_in,
  output logic compare_out
);
  logic [7:0] held;
  // ----------------------------------------------------------------
  // Hold capacitor
  // ----------------------------------------------------------------
  // The capacitor is not discharged between conversions, so a level
  // from an earlier channel persists until the next sampling phase.
  initial held = 8'h00;
  always @(posedge sys_clk_in) begin
    if (sample_hold_in) begin
      held <= {sample_channel_in, ~sample_channel_in};
    end
  end
  assign compare_out = (held >= trial_code_in);
endmodule : sar_adc_analog_model
`default_nettype wire

// File: sar_adc_pkg.sv
// Package with offsets, fields, reset values and counts of the converter.
package sar_adc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ctrl_offset = 4'h0;
  localparam logic [3:0] result_offset = 4'h4;
  localparam logic [3:0] pin_select_offset = 4'h8;
  localparam logic [3:0] intctl_offset = 4'hc;
  // ----------------------------------------------------------------
  // Control and interrupt register fields
  // ----------------------------------------------------------------
  localparam int clk_sel_lsb = 6;
  localparam int chan_lsb = 2;
  localparam int run_bit = 1;
  localparam int power_bit = 0;
  localparam int done_flag_bit = 7;
  // ----------------------------------------------------------------
  // Reset values and leading one
  // ----------------------------------------------------------------
  localparam logic [1:0] clk_sel_reset = 2'h3;
  localparam logic [3:0] chan_reset = 4'hf;
  localparam logic [7:0] pin_select_reset = 8'hff;
  localparam logic [7:0] result_reset = 8'h00;
  localparam logic [7:0] leading_one = 8'h80;
  // ----------------------------------------------------------------
  // Clock select codes and divisors
  // ----------------------------------------------------------------
  localparam logic [1:0] sel_div16 = 2'h0;
  localparam logic [1:0] sel_div8 = 2'h1;
  localparam logic [1:0] sel_div4 = 2'h2;
  localparam logic [1:0] sel_osc = 2'h3;
  localparam logic [4:0] div16 = 5'h10;
  localparam logic [4:0] div8 = 5'h08;
  localparam logic [4:0] div4 = 5'h04;
  // ----------------------------------------------------------------
  // Bit period schedule
  // ----------------------------------------------------------------
  localparam logic [3:0] periods_per_conv = 4'hd;
  localparam logic [3:0] sample_end_period = 4'h1;
  localparam logic [3:0] first_bit_period = 4'h2;
  localparam logic [3:0] last_bit_period = 4'h9;
  localparam logic [3:0] last_period = 4'hc;
endpackage : sar_adc_pkg

// File: sar_adc_sequencer.sv
// Sequencer, register file and pin gating of the 8-bit SAR converter.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] rdata_out,
  input wire logic sleep_in,
  input wire logic osc_tick_in,
  input wire logic compare_in,
  output logic [3:0] sample_channel_out,
  output logic sample_hold_out,
  output logic [7:0] trial_code_out,
  output logic [7:0] analog_pin_select_out,
  input wire logic [7:0] pin_drive_en_in,
  output logic [7:0] pin_drive_en_out,
  output logic conversion_done_flag_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] conv_clock_select;
    logic [3:0] input_channel_select;
    logic converter_power_on;
    logic [7:0] analog_pin_select;
    logic conversion_done_flag;
    logic busy;
    logic [3:0] period;
    logic [7:0] conversion_result;
    logic [7:0] marker;
    logic [1:0] active_clock;
    logic [3:0] active_channel;
    logic sleep_seen;
    logic [7:0] rdata;
  } seq_state_s;

  seq_state_s st;
  seq_state_s next_st;
  logic wr_ctrl;
  logic wr_int;
  logic start;
  logic abort;
  logic sleep_entry;
  logic done;
  logic bit_step;
  logic [7:0] kept;

  bit_period_if bp ();

  bit_period_divider u_div (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .osc_tick_in(osc_tick_in),
    .bp(bp)
  );

  // ----------------------------------------------------------------
  // Decoded events
  // ----------------------------------------------------------------
  assign wr_ctrl = write_in && (addr_in == sar_adc_pkg::ctrl_offset);
  assign wr_int = write_in && (addr_in == sar_adc_pkg::intctl_offset);
  assign sleep_entry = sleep_in && !st.sleep_seen;
  assign start = wr_ctrl && wdata_in[sar_adc_pkg::run_bit] &&
    wdata_in[sar_adc_pkg::power_bit] && !st.busy && !sleep_in;
  assign abort = st.busy && (sleep_entry || sleep_in ||
    (wr_ctrl && (!wdata_in[sar_adc_pkg::run_bit] ||
    !wdata_in[sar_adc_pkg::power_bit])));
  assign done = st.busy && !abort && bp.tick &&
    (st.period == sar_adc_pkg::last_period);
  assign bit_step = st.busy && !abort && bp.tick &&
    (st.period >= sar_adc_pkg::first_bit_period) &&
    (st.period <= sar_adc_pkg::last_bit_period);
  assign bp.restart = start;
  assign bp.sel = st.active_clock;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    kept = 8'h00;
    next_st.sleep_seen = sleep_in;
    if (wr_ctrl) begin
      next_st.conv_clock_select = wdata_in[sar_adc_pkg::clk_sel_lsb +: 2];
      next_st.input_channel_select = wdata_in[sar_adc_pkg::chan_lsb +: 4];
      next_st.converter_power_on = wdata_in[sar_adc_pkg::power_bit];
    end
    if (write_in && (addr_in == sar_adc_pkg::pin_select_offset)) begin
      next_st.analog_pin_select = wdata_in;
    end
    // channel follows register only when idle
    if (!st.busy) begin
      next_st.active_channel = next_st.input_channel_select;
    end
    if (start) begin
      next_st.busy = 1'b1;
      next_st.period = 4'h0;
      next_st.active_clock = next_st.conv_clock_select;
      next_st.active_channel = next_st.input_channel_select;
    end else if (abort) begin
      next_st.busy = 1'b0;
    end else if (st.busy && bp.tick) begin
      next_st.period = st.period + 4'h1;
      // clear and shift in leading one
      if (st.period == sar_adc_pkg::sample_end_period) begin
        next_st.conversion_result = sar_adc_pkg::leading_one;
        next_st.marker = sar_adc_pkg::leading_one;
      end
      if (bit_step) begin
        kept = compare_in ? st.marker : 8'h00;
        next_st.conversion_result = (st.conversion_result & ~st.marker) |
          kept | (st.marker >> 1);
        next_st.marker = st.marker >> 1;
      end
      if (done) begin
        next_st.busy = 1'b0;
      end
    end
    if (wr_int) begin
      next_st.conversion_done_flag = wdata_in[sar_adc_pkg::done_flag_bit];
    end
    if (done) begin
      next_st.conversion_done_flag = 1'b1;
    end
    if (sleep_entry) begin
      next_st.conv_clock_select = sar_adc_pkg::clk_sel_reset;
      next_st.active_clock = sar_adc_pkg::clk_sel_reset;
      next_st.input_channel_select = sar_adc_pkg::chan_reset;
      next_st.active_channel = sar_adc_pkg::chan_reset;
    end
    // Read data stand only in the cycle after the read strobe.
    next_st.rdata = 8'h00;
    if (read_in) begin
      case (addr_in)
        sar_adc_pkg::ctrl_offset: begin
          next_st.rdata = {st.conv_clock_select, st.input_channel_select,
            st.busy, st.converter_power_on};
        end
        sar_adc_pkg::result_offset: begin
          next_st.rdata = st.conversion_result;
        end
        sar_adc_pkg::pin_select_offset: begin
          next_st.rdata = st.analog_pin_select;
        end
        sar_adc_pkg::intctl_offset: begin
          next_st.rdata = {st.conversion_done_flag, 7'h00};
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
      st.conv_clock_select <= sar_adc_pkg::clk_sel_reset;
      st.input_channel_select <= sar_adc_pkg::chan_reset;
      st.analog_pin_select <= sar_adc_pkg::pin_select_reset;
      st.active_clock <= sar_adc_pkg::clk_sel_reset;
      st.active_channel <= sar_adc_pkg::chan_reset;
      st.conversion_result <= sar_adc_pkg::result_reset;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_out = st.rdata;
  assign sample_channel_out = st.active_channel;
  assign sample_hold_out = st.busy &&
    (st.period <= sar_adc_pkg::sample_end_period);
  assign trial_code_out = st.conversion_result;
  assign analog_pin_select_out = st.analog_pin_select;
  // analog pins never drive, power bit ignored
  assign pin_drive_en_out = pin_drive_en_in & ~st.analog_pin_select;
  assign conversion_done_flag_out = st.conversion_done_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_start;
    start;
  endsequence

  sequence s_run_full;
    st.busy [*8];
  endsequence

  property p_no_analog_drive;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (pin_drive_en_out & st.analog_pin_select) == 8'h00;
  endproperty
  a_no_analog_drive: assert property (p_no_analog_drive)
    else $error("Analog pin drives digital output.");

  property p_no_start_unpowered;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (wr_ctrl && !st.busy && !wdata_in[sar_adc_pkg::power_bit]) |=> !st.busy;
  endproperty
  a_no_start_unpowered: assert property (p_no_start_unpowered)
    else $error("Conversion started with power off.");

  property p_done_sets_flag;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      done |=> (st.conversion_done_flag && !st.busy);
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag)
    else $error("Completion did not set flag and clear run.");

  property p_abort_no_flag;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (abort && !wr_int) |=>
        (!st.busy && st.conversion_done_flag == $past(st.conversion_done_flag));
  endproperty
  a_abort_no_flag: assert property (p_abort_no_flag)
    else $error("Abort changed flag or kept running.");

  property p_sleep_stops;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      sleep_entry |=> (!st.busy &&
        st.input_channel_select == sar_adc_pkg::chan_reset &&
        st.conv_clock_select == sar_adc_pkg::clk_sel_reset);
  endproperty
  a_sleep_stops: assert property (p_sleep_stops)
    else $error("Sleep entry left conversion or settings.");

  property p_clock_held;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (st.busy && $past(st.busy) && !$past(start)) |-> $stable(st.active_clock);
  endproperty
  a_clock_held: assert property (p_clock_held)
    else $error("Clock select changed mid-conversion.");

  property p_channel_held;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      s_start ##1 s_run_full |-> $stable(sample_channel_out);
  endproperty
  a_channel_held: assert property (p_channel_held)
    else $error("Channel changed mid-conversion.");

  property p_thirteen_periods;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      done |-> (st.period == sar_adc_pkg::periods_per_conv - 4'h1);
  endproperty
  a_thirteen_periods: assert property (p_thirteen_periods)
    else $error("Conversion length is not thirteen periods.");

  property p_marker_out;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      done |-> (st.marker == 8'h00);
  endproperty
  a_marker_out: assert property (p_marker_out)
    else $error("Leading one not shifted out at completion.");

  property p_idle_unpowered;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (!st.converter_power_on && !st.busy) |=> $stable(st.conversion_result);
  endproperty
  a_idle_unpowered: assert property (p_idle_unpowered)
    else $error("Result changed while powered off.");

  property p_start_runs;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      start |=> st.busy;
  endproperty
  a_start_runs: assert property (p_start_runs)
    else $error("Start write did not raise run.");

  property p_flag_source;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      $rose(st.conversion_done_flag) |-> ($past(done) || $past(wr_int));
  endproperty
  a_flag_source: assert property (p_flag_source)
    else $error("Done flag rose without completion.");

  property p_abort_keeps_result;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      abort |=> $stable(st.conversion_result);
  endproperty
  a_abort_keeps_result: assert property (p_abort_keeps_result)
    else $error("Abort changed the partial result.");

  property p_leading_one;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (bp.tick && !abort && st.busy &&
        st.period == sar_adc_pkg::sample_end_period) |=>
        (st.conversion_result == sar_adc_pkg::leading_one);
  endproperty
  a_leading_one: assert property (p_leading_one)
    else $error("Result not cleared to the leading one after sampling.");

  property p_sleep_no_run;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      sleep_in |=> !st.busy;
  endproperty
  a_sleep_no_run: assert property (p_sleep_no_run)
    else $error("Conversion running during sleep.");

  property p_power_off_idle;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      !st.converter_power_on |-> !st.busy;
  endproperty
  a_power_off_idle: assert property (p_power_off_idle)
    else $error("Sequencer busy while powered off.");
endmodule : sar_adc_sequencer
`default_nettype wire

// File: sar_adc_sequencer_tb_top.sv
// Self-checking testbench of the SAR converter sequencer.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer_tb_top;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic write_in = 1'b0;
  logic read_in = 1'b0;
  logic sleep_in = 1'b0;
  logic osc_tick_in = 1'b0;
  logic [7:0] pin_drive_en_in = 8'hff;
  logic [7:0] rdata_out;
  logic compare_in;
  logic [3:0] sample_channel_out;
  logic sample_hold_out;
  logic [7:0] trial_code_out;
  logic [7:0] analog_pin_select_out;
  logic [7:0] pin_drive_en_out;
  logic conversion_done_flag_out;
  logic [7:0] v;
  logic [3:0] ch;
  logic [2:0] osc_cnt = 3'h0;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int start_cyc = 0;
  int n;
  int dur;
  // ----------------------------------------------------------------
  // Clock, oscillator pulses and instances
  // ----------------------------------------------------------------
  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    osc_cnt <= (osc_cnt == 3'h4) ? 3'h0 : osc_cnt + 3'h1;
    osc_tick_in <= (osc_cnt == 3'h4);
  end
  sar_adc_sequencer u_dut (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
    .rdata_out(rdata_out), .sleep_in(sleep_in), .osc_tick_in(osc_tick_in),
    .compare_in(compare_in), .sample_channel_out(sample_channel_out),
    .sample_hold_out(sample_hold_out), .trial_code_out(trial_code_out),
    .analog_pin_select_out(analog_pin_select_out),
    .pin_drive_en_in(pin_drive_en_in), .pin_drive_en_out(pin_drive_en_out),
    .conversion_done_flag_out(conversion_done_flag_out)
  );
  sar_adc_analog_model u_analog (
    .sys_clk_in(sys_clk_in), .sample_channel_in(sample_channel_out),
    .sample_hold_in(sample_hold_out), .trial_code_in(trial_code_out),
    .compare_out(compare_in)
  );
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    write_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
    write_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    read_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    read_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask : rd
  // Channel is set first and left to settle before the start write.
  task automatic conv(input logic [1:0] sel, input logic [3:0] c);
    wr(sar_adc_pkg::ctrl_offset, {sel, c, 2'b01});
    repeat (8) @(posedge sys_clk_in);
    wr(sar_adc_pkg::ctrl_offset, {sel, c, 2'b11});
    start_cyc = cyc;
  endtask : conv
  task automatic wait_flag;
    n = 0;
    while (conversion_done_flag_out !== 1'b1 && n < 400) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    dur = cyc - start_cyc;
    if (n >= 400) begin
      error_cnt++;
      $display("BAD done flag wait expected 1 seen 0");
      final_report();
    end
  endtask : wait_flag
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    rd(sar_adc_pkg::ctrl_offset, v);
    chk("ctrl reset", v, 8'hfc);
    rd(sar_adc_pkg::pin_select_offset, v);
    chk("pin select reset", v, 8'hff);
    rd(sar_adc_pkg::intctl_offset, v);
    chk("flag reg reset", v, 8'h00);
    chk("pin drive reset", pin_drive_en_out, 8'h00);
    rd(4'h2, v);
    chk("unmapped read", v, 8'h00);
    wr(sar_adc_pkg::pin_select_offset, 8'h0f);
    chk("pin drive power off", pin_drive_en_out, 8'hf0);
    chk("pin select out", analog_pin_select_out, 8'h0f);
    wr(sar_adc_pkg::pin_select_offset, 8'hff);
    wr(sar_adc_pkg::ctrl_offset, 8'h02);
    repeat (60) @(posedge sys_clk_in);
    rd(sar_adc_pkg::ctrl_offset, v);
    chk("run without power", v[1], 1'b0);
    rd(sar_adc_pkg::result_offset, v);
    chk("result power off", v, 8'h00);
    $display("test reset and power-off done");
    for (int i = 0; i < 4; i++) begin
      ch = (i == 3) ? 4'h7 : 4'(i);
      conv(2'(i), ch);
      rd(sar_adc_pkg::ctrl_offset, v);
      chk("run while busy", v[1], 1'b1);
      wait_flag();
      if (i < 3) begin
        chk("duration", 16'(dur), 16'(13 * (16 >> i)));
      end else begin
        chk("osc duration", 16'(dur >= 250 && dur <= 265), 16'h1);
      end
      rd(sar_adc_pkg::result_offset, v);
      chk("result", v, {ch, ~ch});
      chk("trial code", trial_code_out, {ch, ~ch});
      rd(sar_adc_pkg::ctrl_offset, v);
      chk("run after done", v[1], 1'b0);
      chk("done flag", conversion_done_flag_out, 1'b1);
      wr(sar_adc_pkg::intctl_offset, 8'h00);
      chk("flag cleared", conversion_done_flag_out, 1'b0);
    end
    $display("test clock settings done");
    conv(sar_adc_pkg::sel_div16, 4'h2);
    repeat (20) @(posedge sys_clk_in);
    wr(sar_adc_pkg::ctrl_offset, {sar_adc_pkg::sel_div4, 4'h5, 2'b11});
    chk("channel held", sample_channel_out, 4'h2);
    chk("sampling", sample_hold_out, 1'b1);
    wait_flag();
    chk("old clock kept", 16'(dur), 16'd208);
    rd(sar_adc_pkg::result_offset, v);
    chk("old channel result", v, 8'h2d);
    wr(sar_adc_pkg::intctl_offset, 8'h00);
    $display("test deferred settings done");
    conv(sar_adc_pkg::sel_div4, 4'h6);
    repeat (28) @(posedge sys_clk_in);
    wr(sar_adc_pkg::ctrl_offset, {sar_adc_pkg::sel_div4, 4'h6, 2'b01});
    rd(sar_adc_pkg::ctrl_offset, v);
    chk("run after abort", v[1], 1'b0);
    rd(sar_adc_pkg::result_offset, v);
    chk("partial result", v, 8'h6c);
    chk("no flag on abort", conversion_done_flag_out, 1'b0);
    wr(sar_adc_pkg::ctrl_offset, 8'h00);
    repeat (50) @(posedge sys_clk_in);
    rd(sar_adc_pkg::result_offset, v);
    chk("result kept off", v, 8'h6c);
    $display("test abort done");
    conv(sar_adc_pkg::sel_div8, 4'h4);
    repeat (30) @(posedge sys_clk_in);
    sleep_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rd(sar_adc_pkg::ctrl_offset, v);
    chk("ctrl after sleep", v, 8'hfd);
    wr(sar_adc_pkg::ctrl_offset, 8'h03);
    rd(sar_adc_pkg::ctrl_offset, v);
    chk("start in sleep", v[1], 1'b0);
    repeat (150) @(posedge sys_clk_in);
    chk("no flag in sleep", conversion_done_flag_out, 1'b0);
    sleep_in <= 1'b0;
    $display("test sleep done");
    final_report();
  end
endmodule : sar_adc_sequencer_tb_top
`default_nettype wire
